//--- smds_core.sv
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "smds_params.svh"
module smds_core import smds_pkg::*; #(
	parameter int BITS_W = 5
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	// serial pins
	input  wire logic        sclk_in,
	input  wire logic        mosi_in,
	input  wire logic        miso_in,
	input  wire logic        slave_select_in,
	output logic             sclk_out,
	output logic             mosi_out,
	output logic      [3:0]  chip_select_lines,
	// dma counter state
	output logic             dma_busy
);
	// ==========================================================
	// input synchronisers
	logic [3:0] s1_reg, s2_reg, s3_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 4'hf;
			s2_reg <= 4'hf;
			s3_reg <= 4'hf;
		end else begin
			s1_reg <= {slave_select_in, miso_in, mosi_in, sclk_in};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	logic sclk_rise, ss_rise, ss_low, miso_s, mosi_s;
	assign sclk_rise = s2_reg[0] & ~s3_reg[0];
	assign ss_rise   = s2_reg[3] & ~s3_reg[3];
	assign ss_low    = ~s2_reg[3];
	assign mosi_s    = s2_reg[1];
	assign miso_s    = s2_reg[2];

	// ==========================================================
	// registers and flags
	smds_mode_t  mode_reg, mode_next;
	logic [15:0] cscfg_reg, cscfg_next;
	logic [15:0] rxd_reg, rxd_next;
	logic [3:0]  rxpcs_reg, rxpcs_next;
	logic [15:0] txd_reg, txd_next;
	logic [3:0]  txpcs_reg, txpcs_next;
	logic        txlast_reg, txlast_next;
	logic        en_reg, en_next;
	logic        rx_full_flag_reg, rx_full_flag_next, tx_empty_flag_reg, tx_empty_flag_next;
	logic        mode_fault_flag_reg, mode_fault_flag_next, ovr_reg, ovr_next;
	logic        slave_select_rise_reg, slave_select_rise_next, txemp_reg, txemp_next;
	logic        rx_count_done_reg, rx_count_done_next, tx_count_done_reg, tx_count_done_next;
	logic [15:0] rc_reg, rc_next, rnc_reg, rnc_next;
	logic [15:0] tc_reg, tc_next, tnc_reg, tnc_next;
	logic [31:0] rdata_next;
	logic        load_sh, rx_load, last_done;
	logic [15:0] rx_char;
	logic [3:0]  cur_cs;
	logic        fault;
	logic        tx_idle;
	logic        wr_tx, rd_rx, rd_st;
	assign wr_tx = wr && addr == `SMDS_OFF_TX;
	assign rd_rx = rd && addr == `SMDS_OFF_RX;
	assign rd_st = rd && addr == `SMDS_OFF_STATUS;
	assign fault = mode_reg.master && !mode_reg.fdis && ss_low && en_reg;

	// status word
	logic [31:0] status;
	always_comb begin
		status = 32'h0;
		status[`SMDS_ST_RX_FULL_FLAG]  = rx_full_flag_reg;
		status[`SMDS_ST_TX_EMPTY_FLAG]  = tx_empty_flag_reg;
		status[`SMDS_ST_MODE_FAULT_FLAG]  = mode_fault_flag_reg;
		status[`SMDS_ST_OVR]   = ovr_reg;
		status[`SMDS_ST_RX_COUNT_DONE] = rx_count_done_reg;
		status[`SMDS_ST_TX_COUNT_DONE] = tx_count_done_reg;
		status[`SMDS_ST_RXBF]  = rc_reg == 16'h0 && rnc_reg == 16'h0;
		status[`SMDS_ST_TXBE]  = tc_reg == 16'h0 && tnc_reg == 16'h0;
		status[`SMDS_ST_SLAVE_SELECT_RISE]  = slave_select_rise_reg;
		status[`SMDS_ST_TXEMP] = txemp_reg;
		status[`SMDS_ST_ENS]   = en_reg;
	end

	always_comb begin
		mode_next   = mode_reg;
		cscfg_next  = cscfg_reg;
		rxd_next    = rxd_reg;
		rxpcs_next  = rxpcs_reg;
		txd_next    = txd_reg;
		txpcs_next  = txpcs_reg;
		txlast_next = txlast_reg;
		en_next     = en_reg;
		rc_next     = rc_reg;
		rnc_next    = rnc_reg;
		tc_next     = tc_reg;
		tnc_next    = tnc_reg;
		rdata_next  = 32'h0;
		// clears first so that same-cycle sets win
		rx_full_flag_next   = rx_full_flag_reg && !rd_rx;
		tx_empty_flag_next   = tx_empty_flag_reg;
		mode_fault_flag_next   = mode_fault_flag_reg && !rd_st;
		ovr_next    = ovr_reg && !rd_st;
		slave_select_rise_next   = slave_select_rise_reg && !rd_st;
		txemp_next  = txemp_reg;
		rx_count_done_next  = rx_count_done_reg;
		tx_count_done_next  = tx_count_done_reg;
		if (wr) begin
			case (addr)
				`SMDS_OFF_CTRL: begin
					if (wdata[`SMDS_CTRL_DIS]) begin
						en_next   = 1'b0;
						tx_empty_flag_next = 1'b0;
					end else if (wdata[`SMDS_CTRL_EN]) begin
						en_next   = 1'b1;
						tx_empty_flag_next = 1'b1;
					end
					if (wdata[`SMDS_CTRL_LAST])
						txlast_next = 1'b1;
				end
				`SMDS_OFF_MODE: begin
					mode_next.master  = wdata[`SMDS_MODE_MASTER_SELECT];
					mode_next.var_sel = wdata[`SMDS_MODE_VAR];
					mode_next.dec     = wdata[`SMDS_MODE_DEC];
					mode_next.fdis    = wdata[`SMDS_MODE_FDIS];
					mode_next.loopback_enable     = wdata[`SMDS_MODE_LLB];
					mode_next.periph_select_code     = wdata[`SMDS_MODE_PCS_LO +: 4];
					mode_next.dly     = wdata[`SMDS_MODE_DLY_LO +: 8];
				end
				`SMDS_OFF_TX: begin
					txd_next    = wdata[15:0];
					txpcs_next  = wdata[`SMDS_PCS_LO +: 4];
					txlast_next = wdata[`SMDS_TX_LAST] & mode_reg.var_sel;
					tx_empty_flag_next   = 1'b0;
					txemp_next  = 1'b0;
				end
				`SMDS_OFF_CSCFG: cscfg_next = wdata[15:0];
				`SMDS_OFF_DMA_RC: begin
					rc_next    = wdata[15:0];
					rx_count_done_next = 1'b0;
				end
				`SMDS_OFF_DMA_RNC: begin
					rnc_next   = wdata[15:0];
					rx_count_done_next = 1'b0;
				end
				`SMDS_OFF_DMA_TC: begin
					tc_next    = wdata[15:0];
					tx_count_done_next = 1'b0;
				end
				`SMDS_OFF_DMA_TNC: begin
					tnc_next   = wdata[15:0];
					tx_count_done_next = 1'b0;
				end
				default: ;
			endcase
		end
		if (rd) begin
			case (addr)
				`SMDS_OFF_MODE: rdata_next = {mode_reg.dly, 4'h0, mode_reg.periph_select_code, 8'h0,
					mode_reg.loopback_enable, 2'h0, mode_reg.fdis, 1'b0, mode_reg.dec,
					mode_reg.var_sel, mode_reg.master};
				`SMDS_OFF_RX:     rdata_next = {12'h0, rxpcs_reg, rxd_reg};
				`SMDS_OFF_STATUS: rdata_next = status;
				`SMDS_OFF_CSCFG:  rdata_next = {16'h0, cscfg_reg};
				`SMDS_OFF_DMA_RC: rdata_next = {16'h0, rc_reg};
				`SMDS_OFF_DMA_RNC: rdata_next = {16'h0, rnc_reg};
				`SMDS_OFF_DMA_TC: rdata_next = {16'h0, tc_reg};
				`SMDS_OFF_DMA_TNC: rdata_next = {16'h0, tnc_reg};
				default: rdata_next = 32'h0;
			endcase
		end
		// hardware events, after the clears
		if (load_sh) begin
			tx_empty_flag_next = 1'b1;
			if (tc_reg != 16'h0) begin
				tc_next = tc_reg - 16'h1;
				if (tc_reg == 16'h1)
					tx_count_done_next = 1'b1;
			end
		end
		if (rx_load) begin
			rxd_next   = rx_char;
			rxpcs_next = mode_reg.master ? cur_cs : 4'h0;
			rx_full_flag_next  = 1'b1;
			if (rx_full_flag_reg && !rd_rx)
				ovr_next = 1'b1;
			if (rc_reg != 16'h0) begin
				rc_next = rc_reg - 16'h1;
				if (rc_reg == 16'h1)
					rx_count_done_next = 1'b1;
			end
		end
		if (last_done)
			txlast_next = 1'b0;
		if (ss_rise)
			slave_select_rise_next = 1'b1;
		if (fault) begin
			mode_fault_flag_next = 1'b1;
			en_next   = 1'b0;
			tx_empty_flag_next = 1'b0;
		end
		// a load in this cycle means the shifter is about to be busy
		if (tx_idle && !load_sh && tx_empty_flag_next && !wr_tx)
			txemp_next = 1'b1;
	end

	// ==========================================================
	// transfer engine
	smds_state_t st_reg, st_next;
	logic [15:0] sh_reg, sh_next;
	logic [4:0]  cnt_reg, cnt_next;
	logic [7:0]  gap_reg, gap_next;
	logic [7:0]  div_reg, div_next;
	logic [3:0]  cs_reg, cs_next;
	logic        sck_reg, sck_next, mo_reg, mo_next;
	logic [3:0]  want_code, want_lines;
	logic [4:0]  nbits;
	logic [7:0]  gap_len;
	logic        rx_bit;

	assign tx_idle  = st_reg == SMDS_IDLE;
	assign cur_cs   = cs_reg;
	assign nbits    = `SMDS_BASE_BITS + {1'b0, cscfg_reg[`SMDS_CS_BITS_LO +: 4]};
	assign gap_len  = mode_reg.dly > `SMDS_MIN_CS_DLY ? mode_reg.dly : `SMDS_MIN_CS_DLY;
	assign want_code = mode_reg.var_sel ? txpcs_reg : mode_reg.periph_select_code;
	// loopback feeds own output back in master mode
	assign rx_bit   = !mode_reg.master ? mosi_s : (mode_reg.loopback_enable ? mo_reg : miso_s);
	assign rx_char  = sh_reg & ((16'h1 << nbits) - 16'h1);

	always_comb begin
		if (mode_reg.dec)
			want_lines = want_code;
		else if (!want_code[0])
			want_lines = 4'b1110;
		else if (!want_code[1])
			want_lines = 4'b1101;
		else if (!want_code[2])
			want_lines = 4'b1011;
		else if (!want_code[3])
			want_lines = 4'b0111;
		else
			want_lines = `SMDS_CS_IDLE;
	end

	always_comb begin
		st_next  = st_reg;
		sh_next  = sh_reg;
		cnt_next = cnt_reg;
		gap_next = gap_reg;
		div_next = div_reg + 8'h1;
		cs_next  = cs_reg;
		sck_next = sck_reg;
		mo_next  = mo_reg;
		load_sh  = 1'b0;
		rx_load  = 1'b0;
		last_done = 1'b0;
		case (st_reg)
			SMDS_IDLE: begin
				if (en_reg && !tx_empty_flag_reg && mode_reg.master) begin
					if (cs_reg == want_lines || cs_reg == `SMDS_CS_IDLE) begin
						st_next = SMDS_SHIFT;
						cs_next = want_lines;
						load_sh = 1'b1;
						sh_next = txd_reg;
						cnt_next = nbits;
						div_next = 8'h0;
					end else begin
						cs_next  = `SMDS_CS_IDLE;
						// the idle cycle before the restart completes the count
						gap_next = gap_len - 8'h1;
						st_next  = SMDS_GAP;
					end
				end else if (en_reg && !mode_reg.master && ss_low) begin
					st_next  = SMDS_SHIFT;
					load_sh  = !tx_empty_flag_reg;
					sh_next  = tx_empty_flag_reg ? sh_reg : txd_reg;
					cnt_next = nbits;
				end
			end
			SMDS_GAP: begin
				gap_next = gap_reg - 8'h1;
				if (gap_reg == 8'h1)
					st_next = SMDS_IDLE;
			end
			SMDS_SHIFT: begin
				if (mode_reg.master) begin
					if (div_reg == 8'h3) begin
						div_next = 8'h0;
						sck_next = !sck_reg;
						if (!sck_reg)
							mo_next = sh_reg[nbits[3:0] - 4'h1];
						else begin
							sh_next  = {sh_reg[14:0], rx_bit};
							cnt_next = cnt_reg - 5'h1;
						end
					end
				end else if (!ss_low) begin
					// frame cut short by the master: drop the partial character
					st_next = SMDS_IDLE;
				end else if (sclk_rise) begin
					mo_next  = sh_reg[nbits[3:0] - 4'h1];
					sh_next  = {sh_reg[14:0], rx_bit};
					cnt_next = cnt_reg - 5'h1;
				end
				if (cnt_reg == 5'h0)
					st_next = SMDS_DONE;
			end
			SMDS_DONE: begin
				rx_load = 1'b1;
				st_next = SMDS_IDLE;
				if (mode_reg.master && (txlast_reg || !cscfg_reg[`SMDS_CS_HOLD])) begin
					cs_next   = `SMDS_CS_IDLE;
					last_done = 1'b1;
				end
			end
			default: st_next = SMDS_IDLE;
		endcase
		if (!en_reg && st_reg != SMDS_SHIFT) begin
			st_next = SMDS_IDLE;
			cs_next = `SMDS_CS_IDLE;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_reg  <= '0;
			cscfg_reg <= 16'h0;
			rxd_reg   <= 16'h0;
			rxpcs_reg <= 4'h0;
			txd_reg   <= 16'h0;
			txpcs_reg <= 4'h0;
			txlast_reg <= 1'b0;
			en_reg    <= 1'b0;
			rx_full_flag_reg  <= 1'b0;
			tx_empty_flag_reg  <= 1'b0;
			mode_fault_flag_reg  <= 1'b0;
			ovr_reg   <= 1'b0;
			slave_select_rise_reg  <= 1'b0;
			txemp_reg <= 1'b0;
			// counters start at zero, so their end flags start set
			rx_count_done_reg <= 1'b1;
			tx_count_done_reg <= 1'b1;
			rc_reg    <= 16'h0;
			rnc_reg   <= 16'h0;
			tc_reg    <= 16'h0;
			tnc_reg   <= 16'h0;
			rdata     <= 32'h0;
			st_reg    <= SMDS_IDLE;
			sh_reg    <= 16'h0;
			cnt_reg   <= 5'h0;
			gap_reg   <= 8'h0;
			div_reg   <= 8'h0;
			cs_reg    <= `SMDS_CS_IDLE;
			sck_reg   <= 1'b0;
			mo_reg    <= 1'b0;
		end else begin
			mode_reg  <= mode_next;
			cscfg_reg <= cscfg_next;
			rxd_reg   <= rxd_next;
			rxpcs_reg <= rxpcs_next;
			txd_reg   <= txd_next;
			txpcs_reg <= txpcs_next;
			txlast_reg <= txlast_next;
			en_reg    <= en_next;
			rx_full_flag_reg  <= rx_full_flag_next;
			tx_empty_flag_reg  <= tx_empty_flag_next;
			mode_fault_flag_reg  <= mode_fault_flag_next;
			ovr_reg   <= ovr_next;
			slave_select_rise_reg  <= slave_select_rise_next;
			txemp_reg <= txemp_next;
			rx_count_done_reg <= rx_count_done_next;
			tx_count_done_reg <= tx_count_done_next;
			rc_reg    <= rc_next;
			rnc_reg   <= rnc_next;
			tc_reg    <= tc_next;
			tnc_reg   <= tnc_next;
			rdata     <= rdata_next;
			st_reg    <= st_next;
			sh_reg    <= sh_next;
			cnt_reg   <= cnt_next;
			gap_reg   <= gap_next;
			div_reg   <= div_next;
			cs_reg    <= cs_next;
			sck_reg   <= sck_next;
			mo_reg    <= mo_next;
		end
	end

	// outputs straight from flip-flops
	assign sclk_out          = sck_reg;
	assign mosi_out          = mo_reg;
	assign chip_select_lines = cs_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			dma_busy <= 1'b0;
		else
			dma_busy <= (rc_next != 16'h0) || (tc_next != 16'h0);
	end

	// ==========================================================
	// checks
	a_mode_fault_flag_disables: assert property (@(posedge clock) disable iff (!rst_n)
		fault |=> mode_fault_flag_reg && !en_reg) else $error("mode fault missed");
	a_fdis_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		mode_reg.fdis && !wr |=> !(mode_fault_flag_reg && !$past(mode_fault_flag_reg))) else $error("fault while disabled");
	a_rx_full_flag_set: assert property (@(posedge clock) disable iff (!rst_n)
		rx_load |=> rx_full_flag_reg) else $error("rx full not set");
	a_tx_empty_flag_wr: assert property (@(posedge clock) disable iff (!rst_n)
		wr_tx && !fault && !load_sh |=> !tx_empty_flag_reg) else $error("tx empty not cleared");
	a_ovr_set: assert property (@(posedge clock) disable iff (!rst_n)
		rx_load && rx_full_flag_reg && !rd_rx |=> ovr_reg) else $error("overrun missed");
	a_slave_select_rise_keep: assert property (@(posedge clock) disable iff (!rst_n)
		ss_rise |=> slave_select_rise_reg) else $error("select rise lost");
	a_gap_len: assert property (@(posedge clock) disable iff (!rst_n)
		st_reg == SMDS_IDLE && st_next == SMDS_GAP |=> (chip_select_lines == `SMDS_CS_IDLE)[*6])
		else $error("select gap short");
	a_slave_pcs: assert property (@(posedge clock) disable iff (!rst_n)
		rx_load && !mode_reg.master |=> rxpcs_reg == 4'h0) else $error("slave select field");
	a_forbid_idle: assert property (@(posedge clock) disable iff (!rst_n)
		st_reg == SMDS_SHIFT && !mode_reg.dec && want_code == `SMDS_CS_IDLE
		|-> chip_select_lines == `SMDS_CS_IDLE) else $error("bad select");
	c_master_xfer: cover property (@(posedge clock) st_reg == SMDS_DONE && mode_reg.master);
	c_slave_xfer: cover property (@(posedge clock) st_reg == SMDS_DONE && !mode_reg.master);
	c_overrun: cover property (@(posedge clock) ovr_reg);
	c_fault: cover property (@(posedge clock) fault);
endmodule

//--- smds_params.svh
`ifndef SMDS_PARAMS_SVH
`define SMDS_PARAMS_SVH
// register offsets (byte addresses)
`define SMDS_OFF_CTRL      8'h00
`define SMDS_OFF_MODE      8'h04
`define SMDS_OFF_RX        8'h08
`define SMDS_OFF_TX        8'h0c
`define SMDS_OFF_STATUS    8'h10
`define SMDS_OFF_CSCFG     8'h30
`define SMDS_OFF_DMA_RC    8'h40
`define SMDS_OFF_DMA_RNC   8'h44
`define SMDS_OFF_DMA_TC    8'h48
`define SMDS_OFF_DMA_TNC   8'h4c
// control bits
`define SMDS_CTRL_EN       0
`define SMDS_CTRL_DIS      1
`define SMDS_CTRL_LAST     24
// mode fields
`define SMDS_MODE_MASTER_SELECT     0
`define SMDS_MODE_VAR      1
`define SMDS_MODE_DEC      2
`define SMDS_MODE_FDIS     4
`define SMDS_MODE_LLB      7
`define SMDS_MODE_PCS_LO   16
`define SMDS_MODE_DLY_LO   24
`define SMDS_TX_LAST       24
`define SMDS_PCS_LO        16
// status bits
`define SMDS_ST_RX_FULL_FLAG       0
`define SMDS_ST_TX_EMPTY_FLAG       1
`define SMDS_ST_MODE_FAULT_FLAG       2
`define SMDS_ST_OVR        3
`define SMDS_ST_RX_COUNT_DONE      4
`define SMDS_ST_TX_COUNT_DONE      5
`define SMDS_ST_RXBF       6
`define SMDS_ST_TXBE       7
`define SMDS_ST_SLAVE_SELECT_RISE       8
`define SMDS_ST_TXEMP      9
`define SMDS_ST_ENS        16
// chip select config fields
`define SMDS_CS_HOLD       3
`define SMDS_CS_BITS_LO    4
`define SMDS_MIN_CS_DLY    8'h06
`define SMDS_CS_IDLE       4'hf
`define SMDS_BASE_BITS     5'h08
`endif

//--- smds_periph_model.sv
`timescale 1ns/1ps
// ======================================
// serial peripheral on the select lines
module smds_periph_model import smds_pkg::*; (
	// pins seen from the peripheral
	input  wire logic       sclk,
	input  wire logic       mosi,
	input  wire logic [3:0] sel_n,
	output logic            miso,
	output logic      [7:0] got
);
	logic [7:0] shreg = 8'h96;
	logic       drv   = 1'b0;
	logic       selected;
	assign selected = (sel_n !== 4'hf);
	// released line floats to its pull-up level
	assign miso = selected ? drv : 1'b1;
	// data changes on the rising edge and is captured on the falling one
	always @(posedge sclk) begin
		if (selected) begin
			drv   <= shreg[7];
			shreg <= {shreg[6:0], shreg[7]};
		end
	end
	always @(negedge sclk) begin
		if (selected) got <= {got[6:0], mosi};
	end
endmodule

//--- smds_pkg.sv
package smds_pkg;
	typedef struct packed {
		logic [7:0] dly;
		logic [3:0] periph_select_code;
		logic       loopback_enable;
		logic       fdis;
		logic       dec;
		logic       var_sel;
		logic       master;
	} smds_mode_t;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} smds_bus_t;
	typedef enum logic [3:0] {
		SMDS_IDLE  = 4'b0001,
		SMDS_GAP   = 4'b0010,
		SMDS_SHIFT = 4'b0100,
		SMDS_DONE  = 4'b1000
	} smds_state_t;
endpackage

//--- testbench.sv
`timescale 1ns/1ps
`include "smds_params.svh"
module testbench import smds_pkg::*; ;
	logic        clock, rst_n, sclk_in, mosi_in, slave_select_in;
	smds_bus_t   bus;
	wire         miso;
	logic [31:0] rdata, st, rv, st_or;
	logic [7:0]  peer_got;
	logic        sclk_out, mosi_out, dma_busy;
	logic [3:0]  chip_select_lines, seen_sel;
	int          n_mismatch = 0, compares = 0, nonf_cnt = 0, gap_run = 0, last_gap = 0, c;
	logic [3:0]  codes [5] = '{4'h2, 4'h5, 4'hb, 4'h7, 4'h6};
	logic [3:0]  lines [5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h6};
	logic [7:0]  dl [2] = '{8'h03, 8'h0a};
	// ======================================
	// design and far side
	smds_core DUT (.clock(clock), .rst_n(rst_n), .addr(bus.addr), .wdata(bus.wdata),
		.wr(bus.wr), .rd(bus.rd), .rdata(rdata), .sclk_in(sclk_in), .mosi_in(mosi_in),
		.miso_in(miso), .slave_select_in(slave_select_in), .sclk_out(sclk_out),
		.mosi_out(mosi_out), .chip_select_lines(chip_select_lines), .dma_busy(dma_busy));
	smds_periph_model peer (.sclk(sclk_out), .mosi(mosi_out), .sel_n(chip_select_lines),
		.miso(miso), .got(peer_got));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// select line monitor: last code seen and idle run before it
	always @(posedge clock) begin
		if (chip_select_lines !== 4'hf) begin
			seen_sel <= chip_select_lines;
			nonf_cnt <= nonf_cnt + 1;
			if (gap_run != 0) last_gap <= gap_run;
			gap_run <= 0;
		end else begin
			gap_run <= gap_run + 1;
		end
	end
	// ======================================
	// access tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clock);
		bus.rd <= 1'b0;
		#1 d = rdata;
	endtask
	function automatic logic [31:0] mw(input logic m, input logic v, input logic d,
		input logic f, input logic l, input logic [3:0] p, input logic [7:0] dly);
		return {dly, 4'h0, p, 8'h00, l, 2'b00, f, 1'b0, d, v, m};
	endfunction
	// polls status until the shifter has drained
	task automatic xfer(input logic [31:0] w);
		int k;
		wr_reg(`SMDS_OFF_TX, w);
		rd_reg(`SMDS_OFF_STATUS, st);
		st_or = st;
		chk({31'h0, st[`SMDS_ST_TXEMP]}, 32'h0);
		// polling clears read-sensitive flags, so keep every bit seen
		for (k = 0; k < 400 && st[`SMDS_ST_TXEMP] !== 1'b1; k++) begin
			rd_reg(`SMDS_OFF_STATUS, st);
			st_or = st_or | st;
		end
		chk({31'h0, st[`SMDS_ST_TXEMP]}, 32'h1);
	endtask
	task automatic do_reset;
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		rd_reg(`SMDS_OFF_STATUS, st);
		chk(st, 32'h0000_00f0);
	endtask
	task automatic tally_and_finish;
		$display("mismatches=%0d compares=%0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#500000;
		n_mismatch++;
		tally_and_finish();
	end
	// ======================================
	// tests
	initial begin
		rst_n = 1'b0;
		bus = '0;
		sclk_in = 1'b0;
		mosi_in = 1'b0;
		slave_select_in = 1'b1;
		do_reset();
		rd_reg(`SMDS_OFF_MODE, rv);
		chk(rv, 32'h0);
		rd_reg(8'h20, rv);
		chk(rv, 32'h0);
		chk({28'h0, chip_select_lines}, 32'hf);
		wr_reg(`SMDS_OFF_CTRL, 32'h1);
		rd_reg(`SMDS_OFF_STATUS, st);
		chk(st & 32'h0001_0003, 32'h0001_0002);
		wr_reg(`SMDS_OFF_CSCFG, 32'h0);
		for (int i = 0; i < 5; i++) begin
			wr_reg(`SMDS_OFF_MODE, mw(1'b1, 1'b0, i == 4, 1'b0, 1'b1, codes[i], 8'h00));
			xfer({24'h0, 8'ha0 + 8'(i)});
			chk({28'h0, seen_sel}, {28'h0, lines[i]});
			chk({31'h0, st[`SMDS_ST_RX_FULL_FLAG]}, 32'h1);
			rd_reg(`SMDS_OFF_RX, rv);
			chk(rv, {12'h0, lines[i], 8'h00, 8'ha0 + 8'(i)});
			rd_reg(`SMDS_OFF_STATUS, st);
			chk({31'h0, st[`SMDS_ST_RX_FULL_FLAG]}, 32'h0);
		end
		wr_reg(`SMDS_OFF_DMA_RC, 32'h2);
		wr_reg(`SMDS_OFF_DMA_RNC, 32'h0);
		wr_reg(`SMDS_OFF_DMA_TC, 32'h2);
		wr_reg(`SMDS_OFF_DMA_TNC, 32'h0);
		rd_reg(`SMDS_OFF_STATUS, st);
		chk(st & 32'hf0, 32'h0);
		chk({31'h0, dma_busy}, 32'h1);
		xfer(32'h11);
		chk(st_or & 32'hf8, 32'h0);
		xfer(32'h22);
		chk(st_or & 32'hf8, 32'hf8);
		chk({31'h0, dma_busy}, 32'h0);
		rd_reg(`SMDS_OFF_STATUS, st);
		chk({31'h0, st[`SMDS_ST_OVR]}, 32'h0);
		rd_reg(`SMDS_OFF_RX, rv);
		chk(rv, 32'h0006_0022);
		// held select, then a switch to another code
		wr_reg(`SMDS_OFF_CSCFG, 32'h8);
		for (int j = 0; j < 2; j++) begin
			wr_reg(`SMDS_OFF_MODE, mw(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'h0, dl[j]));
			xfer(32'h0000_0031);
			chk({28'h0, chip_select_lines}, 32'he);
			xfer(32'h0101_0032);
			chk(last_gap, (dl[j] > 8'h06) ? 32'(dl[j]) : 32'h6);
			chk({28'h0, seen_sel}, 32'hd);
			chk({28'h0, chip_select_lines}, 32'hf);
		end
		wr_reg(`SMDS_OFF_CSCFG, 32'h0);
		wr_reg(`SMDS_OFF_MODE, mw(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'hf, 8'h00));
		c = nonf_cnt;
		wr_reg(`SMDS_OFF_TX, 32'h55);
		repeat (150) @(posedge clock);
		chk(nonf_cnt - c, 32'h0);
		// plain master receive from the peripheral, loopback off
		wr_reg(`SMDS_OFF_MODE, mw(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 8'h00));
		xfer(32'h5a);
		chk({24'h0, peer_got}, 32'h5a);
		rd_reg(`SMDS_OFF_RX, rv);
		chk(rv, 32'h000e_0096);
		do_reset();
		// mode fault with detection off, then on
		wr_reg(`SMDS_OFF_MODE, mw(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 8'h00));
		wr_reg(`SMDS_OFF_CTRL, 32'h1);
		@(posedge clock);
		slave_select_in <= 1'b0;
		repeat (10) @(posedge clock);
		rd_reg(`SMDS_OFF_STATUS, st);
		chk(st & 32'h0001_0004, 32'h0001_0000);
		wr_reg(`SMDS_OFF_MODE, mw(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 8'h00));
		repeat (10) @(posedge clock);
		rd_reg(`SMDS_OFF_STATUS, st);
		chk(st & 32'h0001_0004, 32'h4);
		slave_select_in <= 1'b1;
		repeat (10) @(posedge clock);
		rd_reg(`SMDS_OFF_STATUS, st);
		chk(st & 32'h0001_0104, 32'h100);
		wr_reg(`SMDS_OFF_CTRL, 32'h1);
		rd_reg(`SMDS_OFF_STATUS, st);
		chk({31'h0, st[`SMDS_ST_ENS]}, 32'h1);
		// slave receive with an 80 ns link clock
		wr_reg(`SMDS_OFF_MODE, 32'h0);
		@(posedge clock);
		slave_select_in <= 1'b0;
		for (int b = 7; b >= 0; b--) begin
			repeat (2) @(posedge clock);
			mosi_in <= 1'(8'h3c >> b);
			repeat (2) @(posedge clock);
			sclk_in <= 1'b1;
			repeat (4) @(posedge clock);
			sclk_in <= 1'b0;
		end
		repeat (6) @(posedge clock);
		slave_select_in <= 1'b1;
		repeat (10) @(posedge clock);
		rd_reg(`SMDS_OFF_STATUS, st);
		chk(st & 32'h101, 32'h101);
		rd_reg(`SMDS_OFF_RX, rv);
		chk(rv, 32'h3c);
		tally_and_finish();
	end
endmodule
